// ===== inc/opfs_pkg.sv
// Purpose: Shared constants for the four-pin output port with function select
// Assumes: 16-bit register port with a word qualifier, byte addresses
// Notes: Drive and function encodings live here so bench and design agree

package opfs_pkg;

	// Register byte addresses
	localparam logic [15:0] ADDR_DATA = 16'hF228;
	localparam logic [15:0] ADDR_DRV_LO = 16'hF22A;
	localparam logic [15:0] ADDR_DRV_HI = 16'hF22B;
	localparam logic [15:0] ADDR_FSEL_LO = 16'hF22C;
	localparam logic [15:0] ADDR_FSEL_HI = 16'hF22D;

	// Reset values
	localparam logic [3:0] RST_DATA = 4'h0;
	localparam logic [3:0] RST_DRV = 4'h0;
	localparam logic [3:0] RST_FSEL = 4'h0;

	// Field layout: implemented bits sit in 3:0, 7:4 read zero
	localparam int FIELD_LSB = 0;
	localparam int FIELD_W = 4;
	localparam logic [3:0] UPPER_ZERO = 4'h0;

	// Drive mode codes {high bit, low bit}
	localparam logic [1:0] DRV_HIZ = 2'h0;
	localparam logic [1:0] DRV_POD = 2'h1;
	localparam logic [1:0] DRV_NOD = 2'h2;
	localparam logic [1:0] DRV_CMOS = 2'h3;

	// Function codes {high bit, low bit}
	localparam logic [1:0] FN_GPIO = 2'h0;
	localparam logic [1:0] FN_SEC = 2'h1;
	localparam logic [1:0] FN_TER = 2'h2;
	localparam logic [1:0] FN_QUA = 2'h3;

endpackage

// ===== core/opfs_pin_mux.sv
// Purpose: Function select for one pin
// Assumes: Sources arrive on the system clock
// Notes: Reserved codes pick a source tied low above, so the chosen level is low

`timescale 1ns/1ps

module opfs_pin_mux
	import opfs_pkg::*;
(
	// Selection
	input wire logic [1:0] fsel,
	// Sources: general data, then codes 01, 10, 11
	input wire logic data_bit,
	input wire logic src_sec,
	input wire logic src_ter,
	input wire logic src_qua,
	// Chosen level
	output logic level
);

	// Pick source by code
	always_comb
	begin
		case (fsel)
			FN_GPIO: level = data_bit;
			FN_SEC: level = src_sec;
			FN_TER: level = src_ter;
			FN_QUA: level = src_qua;
			default: level = data_bit;
		endcase
	end

endmodule // opfs_pin_mux

// ===== core/opfs_pin_drive.sv
// Purpose: Drive-mode decode for one pin
// Assumes: Level already selected
// Notes: Open-drain modes drive only one polarity and release otherwise

`timescale 1ns/1ps

module opfs_pin_drive
	import opfs_pkg::*;
(
	// Controls
	input wire logic [1:0] mode,
	input wire logic level,
	// Pin signals
	output logic pin_out,
	output logic pin_oe
);

	// Drive enable per mode
	always_comb
	begin
		pin_out = level;
		case (mode)
			DRV_HIZ: pin_oe = 1'b0;
			DRV_POD: pin_oe = level;
			DRV_NOD: pin_oe = ~level;
			DRV_CMOS: pin_oe = 1'b1;
			default: pin_oe = 1'b0;
		endcase
	end

endmodule // opfs_pin_drive

// ===== core/opfs_top.sv
// Purpose: Four-pin output-only port with per-pin function and drive mode
// Assumes: One clock mclk at 50 MHz, async active-high rst, plain register port
// Notes: Sources from clock, timer and pulse-width blocks are same-clock logic
//
// What this block does
// - Pin3 codes: 00 data, 10 timerB, 11 pulse_width_output_7
// - Pin2 codes: 00 data, 10 timerA, 11 pulse_width_output_6
// - Pin1 codes: 00 data, 01 fast clock, 10 pulse_width_output_5
// - Pin0 codes: 00 data, 01 slow clock, 10 pulse_width_output_4
// - Function select byte or word access, reset zero
// - Code 00 drives data register bit
// - Output only, no direction register
// - Four drive modes per pin, independent
// - Reset puts every pin high impedance
// - Data bit 0 low, 1 high
// - Drive codes 00 hiz,01 pod,10 nod,11 cmos
// - Data register resets zero, reads back, upper zero
//
// Decided for this implementation: strobed register access.

`timescale 1ns/1ps

module opfs_top
	import opfs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_word,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Alternate sources, same clock
	input wire logic low_speed_clock_out,
	input wire logic high_speed_clock_out,
	input wire logic timer_a_output,
	input wire logic timer_b_output,
	input wire logic pulse_width_output_4,
	input wire logic pulse_width_output_5,
	input wire logic pulse_width_output_6,
	input wire logic pulse_width_output_7,
	// Pins: level and enable, no input side
	output logic [3:0] out_pin,
	output logic [3:0] out_pin_oe
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [3:0] output_data_register;
		logic [3:0] drive_control_low;
		logic [3:0] drive_control_high;
		logic [3:0] pin_function_select_low;
		logic [3:0] pin_function_select_high;
		logic [15:0] rdata;
		logic [3:0] pin;
		logic [3:0] pin_oe;
	} opfs_state_t;

	opfs_state_t st;
	opfs_state_t next_st;

	logic [3:0] sel_level;
	logic [3:0] drv_out;
	logic [3:0] drv_oe;
	logic [1:0] fsel [4];
	logic [1:0] mode [4];
	logic [3:0] src_sec;
	logic [3:0] src_ter;
	logic [3:0] src_qua;

	////////////////////////////////////////////////////////////////////////
	// Per-pin routing

	// Code 01 is unused on pins 2,3 and code 11 on pins 0,1; tied low
	assign src_sec = {1'b0, 1'b0, high_speed_clock_out, low_speed_clock_out};
	assign src_ter = {timer_b_output, timer_a_output, pulse_width_output_5, pulse_width_output_4};
	assign src_qua = {pulse_width_output_7, pulse_width_output_6, 1'b0, 1'b0};

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_pin
			// Function code and drive code pair per pin
			assign fsel[i] = {st.pin_function_select_high[i], st.pin_function_select_low[i]};
			assign mode[i] = {st.drive_control_high[i], st.drive_control_low[i]};

			opfs_pin_mux u_mux
			(
				.fsel(fsel[i]),
				.data_bit(st.output_data_register[i]),
				.src_sec(src_sec[i]),
				.src_ter(src_ter[i]),
				.src_qua(src_qua[i]),
				.level(sel_level[i])
			);

			opfs_pin_drive u_drv
			(
				.mode(mode[i]),
				.level(sel_level[i]),
				.pin_out(drv_out[i]),
				.pin_oe(drv_oe[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Word access at the even address of a pair also writes the odd byte
	always_comb
	begin
		next_st = st;
		next_st.rdata = 16'h0000;
		if (reg_wr)
		begin
			case (reg_addr)
				ADDR_DATA: next_st.output_data_register = reg_wdata[3:0];
				ADDR_DRV_LO:
				begin
					next_st.drive_control_low = reg_wdata[3:0];
					if (reg_word)
						next_st.drive_control_high = reg_wdata[11:8];
				end
				ADDR_DRV_HI: next_st.drive_control_high = reg_wdata[3:0];
				ADDR_FSEL_LO:
				begin
					next_st.pin_function_select_low = reg_wdata[3:0];
					if (reg_word)
						next_st.pin_function_select_high = reg_wdata[11:8];
				end
				ADDR_FSEL_HI: next_st.pin_function_select_high = reg_wdata[3:0];
				default: next_st.rdata = 16'h0000;
			endcase
		end
		// Read data valid only in the cycle after the strobe
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_DATA: next_st.rdata = {8'h00, UPPER_ZERO, st.output_data_register};
				ADDR_DRV_LO:
					next_st.rdata = reg_word ? {4'h0, st.drive_control_high, UPPER_ZERO, st.drive_control_low}
						: {8'h00, UPPER_ZERO, st.drive_control_low};
				ADDR_DRV_HI: next_st.rdata = {8'h00, UPPER_ZERO, st.drive_control_high};
				ADDR_FSEL_LO:
					next_st.rdata = reg_word
						? {4'h0, st.pin_function_select_high, UPPER_ZERO, st.pin_function_select_low}
						: {8'h00, UPPER_ZERO, st.pin_function_select_low};
				ADDR_FSEL_HI: next_st.rdata = {8'h00, UPPER_ZERO, st.pin_function_select_high};
				default: next_st.rdata = 16'h0000;
			endcase
		end
		// Pins are registered; no direction state exists at all
		next_st.pin = drv_out;
		next_st.pin_oe = drv_oe;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	// All pins released while reset holds
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st.output_data_register <= RST_DATA;
			st.drive_control_low <= RST_DRV;
			st.drive_control_high <= RST_DRV;
			st.pin_function_select_low <= RST_FSEL;
			st.pin_function_select_high <= RST_FSEL;
			st.rdata <= 16'h0000;
			st.pin <= 4'h0;
			st.pin_oe <= 4'h0;
		end
		else
			st <= next_st;
	end

	// Outputs straight from flops
	assign reg_rdata = st.rdata;
	assign out_pin = st.pin;
	assign out_pin_oe = st.pin_oe;

endmodule // opfs_top

// ===== bench/opfs_load.sv
// Purpose: LED loads hanging on the four port pins
// Assumes: Each LED pulls its pin up while it is released
// Notes: Nod high and pod low are never driven, so the pull decides
`timescale 1ns/1ps
module opfs_load
(
	// Pins from the port
	input wire logic [3:0] out_pin,
	input wire logic [3:0] out_pin_oe,
	// Level at the pad
	output logic [3:0] pad
);
	// Released pins go to the pull-up level, never the old value
	assign pad = (out_pin & out_pin_oe) | ~out_pin_oe;
endmodule // opfs_load

// ===== bench/opfs_top_asserts.sv
// Purpose: Port-level checks for the output port
// Assumes: Shadow fields follow the register port on the same edge
// Notes: Pins lag a register write by two edges
`timescale 1ns/1ps
module opfs_top_asserts
	import opfs_pkg::*;
(
	// Clock, reset, register port
	input wire logic mclk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_word,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Pins
	input wire logic [3:0] out_pin,
	input wire logic [3:0] out_pin_oe
);
	logic [3:0] dat, dl, dh, fl, fh;
	wire logic [3:0] hz = ~dl & ~dh;
	wire logic [3:0] cm = dl & dh;
	wire logic [3:0] gc = cm & ~fl & ~fh;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Shadow of the writable fields
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			{dat, dl, dh, fl, fh} <= 20'h00000;
		else if (reg_wr)
			case (reg_addr)
				ADDR_DATA: dat <= reg_wdata[3:0];
				ADDR_DRV_LO: {dh, dl} <= {reg_word ? reg_wdata[11:8] : dh, reg_wdata[3:0]};
				ADDR_DRV_HI: dh <= reg_wdata[3:0];
				ADDR_FSEL_LO: {fh, fl} <= {reg_word ? reg_wdata[11:8] : fh, reg_wdata[3:0]};
				ADDR_FSEL_HI: fh <= reg_wdata[3:0];
				default: ;
			endcase
	sequence data_wr_s;
		reg_wr && !reg_word && reg_addr == ADDR_DATA;
	endsequence
	sequence data_rd_s;
		reg_rd && reg_addr == ADDR_DATA;
	endsequence
	// Answers and reserved bits
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	upper_zero_a: assert property ((reg_rdata & 16'hF0F0) == 16'h0000)
		else $error("upper bits not zero");
	no_dir_a: assert property (reg_rd && reg_addr == 16'hF229 |=> reg_rdata == 16'h0000)
		else $error("direction slot answers");
	data_back_a: assert property (data_wr_s ##1 data_rd_s |=> reg_rdata == ($past(reg_wdata, 2) & 16'h000F))
		else $error("data read back wrong");
	// Pin drive follows the fields
	reset_hiz_a: assert property ($fell(rst) |-> out_pin_oe == 4'h0)
		else $error("pin driven after reset");
	hiz_off_a: assert property ((out_pin_oe & $past(hz)) == 4'h0)
		else $error("hiz pin driven");
	cmos_on_a: assert property ((out_pin_oe & $past(cm)) == $past(cm))
		else $error("cmos pin not driven");
	gpio_level_a: assert property (((out_pin ^ $past(dat)) & $past(gc)) == 4'h0)
		else $error("gpio level wrong");
endmodule // opfs_top_asserts
bind opfs_top opfs_top_asserts chk_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_word, .reg_wr, .reg_rd,
	.reg_rdata, .out_pin, .out_pin_oe);

// ===== bench/opfs_top_tb.sv
// Purpose: Self-checking bench for the output port
// Assumes: Tasks start right after a rising edge
// Notes: Random fields carry junk upper bits to probe masking
`timescale 1ns/1ps
module opfs_top_tb import opfs_pkg::*;;
	logic mclk = 0, rst = 1, reg_word = 0, reg_wr = 0, reg_rd = 0;
	logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, v;
	logic [7:0] src = 0, s;
	logic [3:0] out_pin, out_pin_oe, pad, d, dl, dh, fl, fh, lv, j;
	logic [15:0] am [6] = '{ADDR_DATA, ADDR_DRV_LO, ADDR_DRV_HI, ADDR_FSEL_LO, ADDR_FSEL_HI, 16'hF229};
	int fails = 0, checked = 0;
	opfs_top dut_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_word, .reg_wr, .reg_rd, .reg_rdata,
		.low_speed_clock_out(src[0]), .high_speed_clock_out(src[1]), .timer_a_output(src[2]),
		.timer_b_output(src[3]), .pulse_width_output_4(src[4]), .pulse_width_output_5(src[5]),
		.pulse_width_output_6(src[6]), .pulse_width_output_7(src[7]), .out_pin, .out_pin_oe);
	opfs_load load_u (.out_pin, .out_pin_oe, .pad);
	////////////////////////////////////////
	// Clock and watchdog
	initial
		forever #10 mclk = ~mclk;
	initial
	begin
		repeat (10000) @(posedge mclk);
		fails++;
		test_done();
	end
	task automatic chk(string n, logic [15:0] sn, ex);
		checked++;
		if (sn !== ex)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", n, ex, sn);
		end
	endtask
	task automatic test_done;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Write strobe stays up for a following write; the next read drops it
	task automatic wr(logic [15:0] a, dw, logic w);
		{reg_wr, reg_rd, reg_addr, reg_wdata, reg_word} <= {1'b1, 1'b0, a, dw, w};
		@(posedge mclk);
	endtask
	task automatic rd(logic [15:0] a, logic w, output logic [15:0] r);
		{reg_rd, reg_wr, reg_addr, reg_word} <= {1'b1, 1'b0, a, w};
		@(posedge mclk);
		reg_rd <= 0;
		@(negedge mclk);
		r = reg_rdata;
		@(posedge mclk);
	endtask
	// Expected level: code 00 data, 01/10/11 per-pin sources, reserved gives 0
	function automatic logic [3:0] exp_lv(logic [3:0] dd, ll, hh, logic [7:0] ss);
		logic [3:0] c1, c2, c3, e;
		c1 = {2'h0, ss[1], ss[0]};
		c2 = {ss[3], ss[2], ss[5], ss[4]};
		c3 = {ss[7], ss[6], 2'h0};
		for (int i = 0; i < 4; i++)
			e[i] = hh[i] ? (ll[i] ? c3[i] : c2[i]) : (ll[i] ? c1[i] : dd[i]);
		return e;
	endfunction
	////////////////////////////////////////
	// Two resets, random traffic between them
	initial
	begin
		void'($urandom(32'hC0EA));
		for (int p = 0; p < 2; p++)
		begin
			rst <= 1;
			repeat (12) @(posedge mclk);
			rst <= 0;
			@(posedge mclk);
			foreach (am[i])
			begin
				rd(am[i], 0, v);
				chk("reset value", v, 16'h0000);
			end
			@(negedge mclk);
			chk("reset oe", {12'h000, out_pin_oe}, 16'h0000);
			@(posedge mclk);
			$display("reset test done");
			for (int k = 0; k < 60 && p == 0; k++)
			begin
				{d, dl, dh, fl, fh, s, j} = $urandom;
				src <= s;
				wr(ADDR_DATA, {12'hFFF, d}, 0);
				rd(ADDR_DATA, 0, v);
				chk("data", v, {12'h000, d});
				if (j[0])
				begin
					wr(ADDR_DRV_LO, {4'hF, dh, 4'hF, dl}, 1);
					wr(ADDR_FSEL_LO, {4'hF, fh, 4'hF, fl}, 1);
				end
				else
				begin
					wr(ADDR_DRV_LO, {12'hFFF, dl}, 0);
					wr(ADDR_DRV_HI, {12'hFFF, dh}, 0);
					wr(ADDR_FSEL_LO, {12'hFFF, fl}, 0);
					wr(ADDR_FSEL_HI, {12'hFFF, fh}, 0);
				end
				rd(ADDR_DRV_LO, 1, v);
				chk("drive word", v, {4'h0, dh, 4'h0, dl});
				rd(ADDR_FSEL_LO, 1, v);
				chk("fsel word", v, {4'h0, fh, 4'h0, fl});
				rd(ADDR_FSEL_HI, 0, v);
				chk("fsel high", v, {12'h000, fh});
				rd(16'hF229, 0, v);
				chk("no direction", v, 16'h0000);
				lv = exp_lv(d, fl, fh, s);
				@(negedge mclk);
				chk("pad", {12'h000, pad}, {12'h000, ~(dh & ~lv)});
				chk("oe", {12'h000, out_pin_oe}, {12'h000, dh & dl | dl & ~dh & lv | dh & ~dl & ~lv});
				@(posedge mclk);
			end
			$display("pass %0d done", p);
		end
		test_done();
	end
endmodule // opfs_top_tb
